// ---- pie_regs.svh ----
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH

// Register byte offsets on the plain register port.
`define PIE_OFS_ENABLE 8'h00
`define PIE_OFS_PENDING 8'h04
`define PIE_OFS_STATUS 8'h08
`define PIE_OFS_MASK 8'h0C

// Bit positions inside the enable register and its companions.
`define PIE_BIT_OSC_FAIL 7
`define PIE_BIT_COMPARATOR 6
`define PIE_BIT_BUS_COLLISION 3
`define PIE_BIT_VOLTAGE_DETECT 2
`define PIE_BIT_TIMER_THREE 1
`define PIE_BIT_CAPCOMP_TWO 0

// Positions that exist in hardware; bits 5 and 4 are not implemented.
`define PIE_IMPL_MASK 8'hCF

// Reset values.
`define PIE_RST_ENABLE 8'h00
`define PIE_RST_STATUS 8'h00
`define PIE_RST_MASK 8'h00
`define PIE_RST_RDATA 8'h00

`endif

// ---- pie_pkg.sv ----
package pie_pkg;

    // Width of every register and of the source vector.
    localparam int unsigned DATA_W = 8;

    // One access from the register master, carried as a single bundle.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pie_bus_req_t;

    // Names of the register slots, for readability of the decode.
    typedef enum logic [1:0] {
        PIE_SEL_ENABLE = 2'h0,
        PIE_SEL_PENDING = 2'h1,
        PIE_SEL_STATUS = 2'h2,
        PIE_SEL_MASK = 2'h3
    } pie_sel_t;

endpackage : pie_pkg

// ---- pie_src_cell.sv ----
// One interrupt source: gates its flag by its enable bit and keeps a
// sticky event bit that records each new forwarded request.
module pie_src_cell (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic flag,
    input wire logic enable,
    input wire logic clearStatus,
    output logic reqOut,
    output logic statusOut
);

    // Forward only while the flag and the enable are both high.
    logic req_next;
    // A new request appears when the gated level goes from low to high.
    logic rise;
    // Sticky event bit; a set in the clearing cycle wins over the clear.
    logic status_next;

    assign req_next = flag & enable;
    assign rise = req_next & ~reqOut;
    assign status_next = rise | (statusOut & ~clearStatus);

    // Both outputs are flops so the top drives its pins from registers.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reqOut <= 1'b0;
            statusOut <= 1'b0;
        end else begin
            reqOut <= req_next;
            statusOut <= status_next;
        end
    end

endmodule : pie_src_cell

// ---- pie_irq_enable.sv ----
// Contract
// - Oscillator fail enable: 1 passes, 0 blocks.
// - Comparator enable: 1 permits, 0 suppresses.
// - Unimplemented bits read zero, ignore writes.
// - Bus collision enable: 1 passes, 0 masks.
// - Voltage detect enable: 1 enables, 0 disables.
// - Timer three overflow enable gates rollover.
// - Capture/compare two enable gates its interrupt.
//
// Added by the designer: the strobed register port and the register offsets.
`include "pie_regs.svh"

module pie_irq_enable #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire pie_pkg::pie_bus_req_t busReq,
    input wire logic [WIDTH-1:0] srcFlag,
    output logic [WIDTH-1:0] rdData,
    output logic [WIDTH-1:0] irqReq,
    output logic irq
);

    // Which register the current access addresses.
    logic hitEnable;
    logic hitPending;
    logic hitStatus;
    logic hitMask;
    // Any address outside the four slots.
    logic hitNone;

    // Software-owned enable and mask registers.
    logic [WIDTH-1:0] enable_reg;
    logic [WIDTH-1:0] enable_next;
    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] mask_next;

    // Named views of the enable fields. The enable_reg flops hold the
    // peripheral_irq_enable_two register; each field gates one source.
    logic osc_fail_irq_en;
    logic comparator_irq_en;
    logic bus_collision_irq_en;
    logic voltage_detect_irq_en;
    logic timer_three_overflow_irq_en;
    logic capcomp_two_irq_en;

    // Sticky event bits out of the per-source cells.
    logic [WIDTH-1:0] statusBits;
    // Write-one-to-clear vector for the event bits.
    logic [WIDTH-1:0] statusClear;

    // Read data path and the interrupt level.
    logic [WIDTH-1:0] rdData_next;
    logic irq_next;

    // Address decode is purely combinational on the access bundle.
    assign hitEnable = busReq.addr == `PIE_OFS_ENABLE;
    assign hitPending = busReq.addr == `PIE_OFS_PENDING;
    assign hitStatus = busReq.addr == `PIE_OFS_STATUS;
    assign hitMask = busReq.addr == `PIE_OFS_MASK;
    assign hitNone = !(hitEnable || hitPending || hitStatus || hitMask);

    // Writes to the enable register drop the unimplemented positions, so
    // those bits stay zero whatever software writes.
    assign enable_next = (busReq.wr && hitEnable)
        ? (busReq.wdata & `PIE_IMPL_MASK) : enable_reg;

    // Field views of the enable register, one per gated source.
    assign osc_fail_irq_en = enable_reg[`PIE_BIT_OSC_FAIL];
    assign comparator_irq_en = enable_reg[`PIE_BIT_COMPARATOR];
    assign bus_collision_irq_en = enable_reg[`PIE_BIT_BUS_COLLISION];
    assign voltage_detect_irq_en = enable_reg[`PIE_BIT_VOLTAGE_DETECT];
    assign timer_three_overflow_irq_en =
        enable_reg[`PIE_BIT_TIMER_THREE];
    assign capcomp_two_irq_en = enable_reg[`PIE_BIT_CAPCOMP_TWO];

    // The mask follows the same layout and the same trimming.
    assign mask_next = (busReq.wr && hitMask)
        ? (busReq.wdata & `PIE_IMPL_MASK) : mask_reg;

    // Writing a one clears an event bit; other writes leave it alone.
    assign statusClear = (busReq.wr && hitStatus) ? busReq.wdata : 8'h00;

    // Read mux. Unmapped addresses answer zero rather than stale data.
    assign rdData_next = !busReq.rd ? `PIE_RST_RDATA
        : hitEnable ? enable_reg
        : hitPending ? (srcFlag & `PIE_IMPL_MASK)
        : hitStatus ? statusBits
        : hitMask ? mask_reg
        : `PIE_RST_RDATA;

    // The level interrupt follows any event bit that the mask lets by.
    assign irq_next = |(statusBits & mask_reg);

    // Software registers and the registered read answer.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_reg <= `PIE_RST_ENABLE;
            mask_reg <= `PIE_RST_MASK;
            rdData <= `PIE_RST_RDATA;
        end else begin
            enable_reg <= enable_next;
            mask_reg <= mask_next;
            rdData <= rdData_next;
        end
    end

    // Interrupt output flop; one cycle behind the event bits, which keeps
    // the pin glitch free at the cost of a cycle of latency.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    // One gating cell per position. Unimplemented positions get a cell
    // too, but their enable is held at zero, so they never forward.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_src
            pie_src_cell u_cell (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .flag(srcFlag[gi]),
                .enable(enable_reg[gi]),
                .clearStatus(statusClear[gi]),
                .reqOut(irqReq[gi]),
                .statusOut(statusBits[gi])
            );
        end
    endgenerate

    // Checks run on the block clock and are off while reset is low.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Oscillator fail request follows its flag only when enabled.
    property p_osc_fail_gate;
        irqReq[`PIE_BIT_OSC_FAIL] == $past(srcFlag[`PIE_BIT_OSC_FAIL]
            && enable_reg[`PIE_BIT_OSC_FAIL]);
    endproperty
    a_osc_fail_gate: assert property (p_osc_fail_gate)
        else $error("Oscillator fail request does not follow its enable.");

    // A blocked comparator flag never reaches the request pin.
    property p_comparator_block;
        (srcFlag[`PIE_BIT_COMPARATOR] && !enable_reg[`PIE_BIT_COMPARATOR])
            |=> !irqReq[`PIE_BIT_COMPARATOR];
    endproperty
    a_comparator_block: assert property (p_comparator_block)
        else $error("Comparator request passed while disabled.");

    // Enabling via the register passes a steady comparator flag.
    property p_comparator_pass;
        (busReq.wr && hitEnable && busReq.wdata[`PIE_BIT_COMPARATOR]
            && srcFlag[`PIE_BIT_COMPARATOR])
            ##1 srcFlag[`PIE_BIT_COMPARATOR] |=> irqReq[`PIE_BIT_COMPARATOR];
    endproperty
    a_comparator_pass: assert property (p_comparator_pass)
        else $error("Comparator request missing after enable write.");

    // Unimplemented positions read zero from the enable register.
    property p_unimpl_read;
        (busReq.rd && hitEnable) |=> rdData[5:4] == 2'h0;
    endproperty
    a_unimpl_read: assert property (p_unimpl_read)
        else $error("Unimplemented enable bits read non-zero.");

    // Writes of ones to the unimplemented positions leave them clear.
    property p_unimpl_write;
        (busReq.wr && hitEnable)
            |=> (enable_reg[5:4] == 2'h0 && !irqReq[5] && !irqReq[4]) [*2];
    endproperty
    a_unimpl_write: assert property (p_unimpl_write)
        else $error("Unimplemented enable bits took a write.");

    // Bus collision request is masked while its enable is zero.
    property p_bus_collision;
        !enable_reg[`PIE_BIT_BUS_COLLISION] [*2]
            |-> !irqReq[`PIE_BIT_BUS_COLLISION];
    endproperty
    a_bus_collision: assert property (p_bus_collision)
        else $error("Bus collision request passed while masked.");

    // Voltage detect request rises only with its flag and enable.
    property p_voltage_detect;
        $rose(irqReq[`PIE_BIT_VOLTAGE_DETECT])
            |-> $past(srcFlag[`PIE_BIT_VOLTAGE_DETECT])
            && $past(enable_reg[`PIE_BIT_VOLTAGE_DETECT]);
    endproperty
    a_voltage_detect: assert property (p_voltage_detect)
        else $error("Voltage detect request rose without cause.");

    // Timer three request drops one cycle after its enable is cleared.
    property p_timer_three;
        $fell(enable_reg[`PIE_BIT_TIMER_THREE])
            |-> ##1 !irqReq[`PIE_BIT_TIMER_THREE];
    endproperty
    a_timer_three: assert property (p_timer_three)
        else $error("Timer three request outlived its enable.");

    // Capture/compare two request tracks flag and enable together.
    property p_capcomp_two;
        (srcFlag[`PIE_BIT_CAPCOMP_TWO] && enable_reg[`PIE_BIT_CAPCOMP_TWO])
            |=> irqReq[`PIE_BIT_CAPCOMP_TWO];
    endproperty
    a_capcomp_two: assert property (p_capcomp_two)
        else $error("Capture/compare two request missing.");

    // The whole request vector is the registered flag-and-enable product.
    property p_forward_all;
        irqReq == $past(srcFlag & enable_reg);
    endproperty
    a_forward_all: assert property (p_forward_all)
        else $error("Request vector differs from flag and enable.");

    // A disabled oscillator fail source never forwards.
    property p_osc_fail_block;
        !osc_fail_irq_en |=> !irqReq[`PIE_BIT_OSC_FAIL];
    endproperty
    a_osc_fail_block: assert property (p_osc_fail_block)
        else $error("Oscillator fail request passed while disabled.");

    // An enabled comparator flag reaches its request in the next cycle.
    property p_comparator_enabled;
        (srcFlag[`PIE_BIT_COMPARATOR] && comparator_irq_en)
            |=> irqReq[`PIE_BIT_COMPARATOR];
    endproperty
    a_comparator_enabled: assert property (p_comparator_enabled)
        else $error("Comparator request missing while enabled.");

    // An enabled bus collision flag is passed on in the next cycle.
    property p_bus_collision_pass;
        (srcFlag[`PIE_BIT_BUS_COLLISION] && bus_collision_irq_en)
            |=> irqReq[`PIE_BIT_BUS_COLLISION];
    endproperty
    a_bus_collision_pass: assert property (p_bus_collision_pass)
        else $error("Bus collision request missing while enabled.");

    // A disabled voltage detector never forwards.
    property p_voltage_block;
        !voltage_detect_irq_en |=> !irqReq[`PIE_BIT_VOLTAGE_DETECT];
    endproperty
    a_voltage_block: assert property (p_voltage_block)
        else $error("Voltage detect request passed while disabled.");

    // An enabled timer three rollover flag is passed on.
    property p_timer_three_pass;
        (srcFlag[`PIE_BIT_TIMER_THREE] && timer_three_overflow_irq_en)
            |=> irqReq[`PIE_BIT_TIMER_THREE];
    endproperty
    a_timer_three_pass: assert property (p_timer_three_pass)
        else $error("Timer three request missing while enabled.");

    // A disabled capture/compare two source never forwards.
    property p_capcomp_two_block;
        !capcomp_two_irq_en |=> !irqReq[`PIE_BIT_CAPCOMP_TWO];
    endproperty
    a_capcomp_two_block: assert property (p_capcomp_two_block)
        else $error("Capture/compare two request passed while disabled.");

    // The interrupt pin is the masked event vector, one cycle late.
    property p_irq_level;
        irq == $past(|(statusBits & mask_reg));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt level differs from masked events.");

    // An unmapped read answers zero in the next cycle.
    property p_unmapped_read;
        (busReq.rd && hitNone) |=> rdData == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped read did not return zero.");

    // The event bit is set at the edge that raises the request, so an
    // unmasked event shows on the pin one cycle after the request. A
    // clear in that cycle cannot hide it, since irq samples the bit first.
    property p_irq_raise;
        ($rose(irqReq[0]) && mask_reg[0]) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("Unmasked event did not raise the interrupt.");

    // Main scenarios worth seeing in simulation.
    property p_cov_enable_write;
        busReq.wr && hitEnable && busReq.wdata != 8'h00;
    endproperty
    c_enable_write: cover property (p_cov_enable_write);

    property p_cov_irq_rise;
        $rose(irq);
    endproperty
    c_irq_rise: cover property (p_cov_irq_rise);

    property p_cov_status_clear;
        irq ##1 (busReq.wr && hitStatus) ##2 !irq;
    endproperty
    c_status_clear: cover property (p_cov_status_clear);

    property p_cov_all_forward;
        irqReq == `PIE_IMPL_MASK;
    endproperty
    c_all_forward: cover property (p_cov_all_forward);

    property p_cov_masked_event;
        statusBits[`PIE_BIT_TIMER_THREE] && !mask_reg[`PIE_BIT_TIMER_THREE];
    endproperty
    c_masked_event: cover property (p_cov_masked_event);

endmodule : pie_irq_enable

// ---- pie_irq_enable_tb.sv ----
`include "pie_regs.svh"

// Self-checking bench for the enable register and its request gating.
module pie_irq_enable_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk; // System clock, 8 ns period.
    logic rstn; // Active low reset.
    pie_pkg::pie_bus_req_t busReq; // Register port request.
    logic [7:0] srcFlag; // Pending flags of the sources.
    logic [7:0] rdData; // Read answer.
    logic [7:0] irqReq; // Forwarded requests.
    logic irq; // Level interrupt.
    int fail_count; // Mismatches seen.
    int samples_checked; // Comparisons made.
    int cycleCount; // Watchdog count of clock cycles.
    logic [7:0] enVal; // Random enable value.
    logic [7:0] flagVal; // Random flag value.

    pie_irq_enable #(.WIDTH(8)) pie_irq_enable_inst (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .busReq(busReq),
        .srcFlag(srcFlag),
        .rdData(rdData),
        .irqReq(irqReq),
        .irq(irq)
    );

    // Free-running clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Expected requests: only implemented, enabled and flagged sources.
    function automatic logic [7:0] expReq(input logic [7:0] e,
                                          input logic [7:0] f);
        return e & f & 8'hCF;
    endfunction : expReq

    // Expected requests with every flag raised and one enable set.
    function automatic logic [7:0] expOne(input int i);
        return expReq(8'h01 << i, 8'hFF);
    endfunction : expOne

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits n edges, then lets their updates settle before sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // One-cycle write strobe; the next access waits a fresh edge.
    task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        busReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        busReq.wr <= 1'b0;
    endtask : wrReg

    // One-cycle read; the answer stands only in the following cycle.
    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk);
        busReq <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        busReq.rd <= 1'b0;
        #1;
        check(rdData, exp);
    endtask : rdChk

    // Drives the flags at an edge and samples n settled cycles later.
    task automatic setFlags(input logic [7:0] f, input int n);
        @(posedge ref_clk);
        srcFlag <= f;
        tick(n);
    endtask : setFlags

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Watchdog: a hang counts as a mismatch.
    always @(posedge ref_clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // Main sequence.
    initial begin
        rstn = 1'b0;
        busReq = '0;
        srcFlag = 8'h00;
        fail_count = 0;
        samples_checked = 0;
        cycleCount = 0;
        void'($urandom(32'h1866CFA8));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        // Reset contents, and an unmapped read that must answer zero.
        rdChk(`PIE_OFS_ENABLE, 8'h00);
        rdChk(`PIE_OFS_STATUS, 8'h00);
        rdChk(`PIE_OFS_MASK, 8'h00);
        rdChk(8'h10, 8'h00);
        // Unimplemented positions must never hold a one.
        wrReg(`PIE_OFS_ENABLE, 8'hFF);
        rdChk(`PIE_OFS_ENABLE, 8'hCF);
        wrReg(`PIE_OFS_ENABLE, 8'h30);
        rdChk(`PIE_OFS_ENABLE, 8'h00);
        wrReg(`PIE_OFS_PENDING, 8'hFF);
        rdChk(`PIE_OFS_PENDING, 8'h00);
        // Each position alone, with every flag raised.
        for (int i = 0; i < 8; i++) begin
            wrReg(`PIE_OFS_ENABLE, 8'h01 << i);
            setFlags(8'hFF, 1);
            check(irqReq, expOne(i));
        end
        // Random enables against random flags.
        for (int i = 0; i < 60; i++) begin
            enVal = 8'($urandom);
            flagVal = 8'($urandom);
            wrReg(`PIE_OFS_ENABLE, enVal);
            setFlags(flagVal, 1);
            check(irqReq, expReq(enVal, flagVal));
            rdChk(`PIE_OFS_PENDING, flagVal & 8'hCF);
        end
        // Clean start for the interrupt path.
        setFlags(8'h00, 1);
        wrReg(`PIE_OFS_ENABLE, 8'h01);
        wrReg(`PIE_OFS_MASK, 8'h01);
        wrReg(`PIE_OFS_STATUS, 8'hFF);
        tick(2);
        check({7'h00, irq}, 8'h00);
        // Enabled and unmasked source raises the interrupt.
        setFlags(8'h01, 1);
        check(irqReq, 8'h01);
        tick(1);
        check({7'h00, irq}, 8'h01);
        rdChk(`PIE_OFS_STATUS, 8'h01);
        // Clearing by writing one; the flag stays high, so no new event.
        wrReg(`PIE_OFS_STATUS, 8'h01);
        tick(2);
        check({7'h00, irq}, 8'h00);
        rdChk(`PIE_OFS_STATUS, 8'h00);
        // Enabled but masked source records status without interrupt.
        wrReg(`PIE_OFS_ENABLE, 8'h03);
        setFlags(8'h03, 2);
        check({7'h00, irq}, 8'h00);
        rdChk(`PIE_OFS_STATUS, 8'h02);
        // Disabled sources neither forward nor record anything.
        wrReg(`PIE_OFS_ENABLE, 8'h00);
        setFlags(8'h8B, 2);
        check(irqReq, 8'h00);
        rdChk(`PIE_OFS_STATUS, 8'h02);
        wrReg(`PIE_OFS_MASK, 8'hFF);
        rdChk(`PIE_OFS_MASK, 8'hCF);
        // A mid-run reset clears the event bits and every output, even
        // with flags still raised, and leaves all sources disabled.
        @(posedge ref_clk);
        rstn <= 1'b0;
        tick(2);
        check(irqReq, 8'h00);
        check({7'h00, irq}, 8'h00);
        @(posedge ref_clk);
        rstn <= 1'b1;
        rdChk(`PIE_OFS_STATUS, 8'h00);
        rdChk(`PIE_OFS_ENABLE, 8'h00);
        rdChk(`PIE_OFS_MASK, 8'h00);
        test_done();
    end
endmodule : pie_irq_enable_tb
